// File: hdl/smc_pkg.sv
// Package with register map, field positions and timing constants of the standby controller
package smc_pkg;
	// Register byte addresses (word aligned)
	localparam logic [31:0] ADDR_WAIT_SEL   = 32'hFFFFF6C0;
	localparam logic [31:0] ADDR_PWR_CTRL   = 32'hFFFFF6C4;
	localparam logic [31:0] ADDR_PWR_MODE   = 32'hFFFFF6C8;
	localparam logic [31:0] ADDR_PROTECT    = 32'hFFFFF6CC;
	localparam logic [31:0] ADDR_STATUS     = 32'hFFFFF6D0;
	// Reset values
	localparam logic [7:0]  RST_WAIT_SEL    = 8'h01;
	localparam logic [7:0]  RST_PWR_CTRL    = 8'h00;
	localparam logic [7:0]  RST_PWR_MODE    = 8'h00;
	// Power save control fields
	localparam int          BIT_WDT2_DIS    = 7;
	localparam int          BIT_NMI_DIS     = 5;
	localparam int          BIT_MASK_DIS    = 4;
	localparam int          BIT_STANDBY     = 1;
	localparam logic [7:0]  PWR_CTRL_MASK   = 8'hB2;
	// Power save mode field
	localparam int          BIT_DEEP        = 0;
	localparam logic [7:0]  PWR_MODE_MASK   = 8'h01;
	// Wait select field
	localparam logic [7:0]  WAIT_SEL_MASK   = 8'h07;
	// Protect unlock key, value arbitrary
	localparam logic [7:0]  PROTECT_KEY     = 8'hA5;
	// Wait exponents
	localparam int          WAIT_EXP_MIN    = 13;
	localparam int          WAIT_EXP_BASE   = 14;
	localparam int          WAIT_EXP_MAX    = 21;
	// Controller states
	typedef enum logic [2:0]
	{
		ST_RUN    = 3'b000,
		ST_HALT   = 3'b001,
		ST_IDLE   = 3'b010,
		ST_STOP   = 3'b011,
		ST_OSC    = 3'b100,
		ST_SETTLE = 3'b101
	} smc_state_t;
endpackage : smc_pkg

// File: hdl/smc_wait_counter.sv
// Oscillation stabilization counter on the main clock
`timescale 1ns/1ps
module smc_wait_counter #(
	parameter int WIDTH = 22
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Control
	input  wire logic             start_i,
	input  wire logic [2:0]       sel_i,
	// Result
	output logic                  done_o
);
	logic [WIDTH-1:0] count_reg;
	logic             run_reg;
	logic [4:0]       exp_sel;

	initial
	begin
		if (WIDTH < smc_pkg::WAIT_EXP_MAX + 1)
			$error("smc_wait_counter: WIDTH too small");
	end

	// Code 0 is 2^13, others 2^(14+code)
	always_comb
	begin
		if (sel_i == 3'h0)
			exp_sel = 5'(smc_pkg::WAIT_EXP_MIN);
		else
			exp_sel = 5'(smc_pkg::WAIT_EXP_BASE) + 5'(sel_i);
	end

	// Count main clock periods until the power of two is reached
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count_reg <= '0;
			run_reg   <= 1'b0;
			done_o    <= 1'b0;
		end
		else if (start_i)
		begin
			count_reg <= '0;
			run_reg   <= 1'b1;
			done_o    <= 1'b0;
		end
		else if (run_reg)
		begin
			count_reg <= count_reg + 1'b1;
			if (count_reg[exp_sel] == 1'b0 && count_reg == (WIDTH'(1) << exp_sel) - WIDTH'(1))
			begin
				run_reg <= 1'b0;
				done_o  <= 1'b1;
			end
		end
		else
			done_o <= 1'b0;
	end
endmodule : smc_wait_counter

// File: hdl/smc_standby_ctrl.sv
// Standby mode controller with Wishbone register slave
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Power save control written only right after the protect key write.
// - Power save control is 8 bits, resets to zero.
// - Bits 7, 5, 4 disable wake by watchdog2, pin NMI, maskable requests.
// - Bit 1 requests standby in the mode chosen by mode select.
// - Mode select acts only while the standby request is set.
// - Power save mode register is 8 bits, resets to zero.
// - Three-bit code picks 2^13 or 2^15..2^21 main clock wait.
// - Wait select register is byte access, resets to 01.
// - Wait count starts only once oscillation has started.
// - After reset the wait is 2^15 periods.
// - Wait is inserted even with an external main clock.
// - Halt gates only the CPU clock; peripherals keep running.
// - Halt with a pending unmasked request leaves at once.
// - Halt released by NMI, either watchdog, unmasked request, resets.
// - Lower priority request ends standby only, stays pending.
// - Higher priority or non-maskable request ends standby and is acknowledged.
// - NMI vectors; maskable vectors if enabled, else continues.
// - Mode select 0 plus standby request enters idle, peripherals stopped.
// - Leaving idle needs no stabilization wait.
// - Idle released by NMI, watchdog2 on subclock, pins, live peripherals, reset.
module smc_standby_ctrl (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	// CPU core
	input  wire logic        halt_exec_i,
	input  wire logic        in_service_i,
	input  wire logic [3:0]  service_level_i,
	input  wire logic        int_enabled_i,
	output logic             cpu_clk_en_o,
	output logic             periph_clk_en_o,
	output logic             osc_en_o,
	output logic             wake_o,
	output logic             wake_vector_o,
	// Interrupt controller
	input  wire logic        pin_nmi_i,
	input  wire logic        watchdog1_interrupt_i,
	input  wire logic        watchdog2_interrupt_i,
	input  wire logic        on_subclock_i,
	input  wire logic        mask_req_i,
	input  wire logic [3:0]  mask_req_level_i,
	input  wire logic        ext_pin_req_i,
	input  wire logic        idle_live_req_i,
	output logic             ack_req_o,
	// Reset sources and oscillator
	input  wire logic        pin_reset_i,
	input  wire logic        watchdog1_reset_i,
	input  wire logic        watchdog2_reset_i,
	input  wire logic        osc_started_i,
	output logic             sys_reset_o
);
	logic [7:0]             wait_sel_reg;
	logic [7:0]             pwr_ctrl_reg;
	logic [7:0]             pwr_mode_reg;
	logic                   unlock_reg;
	smc_pkg::smc_state_t    state_reg;
	logic                   wait_start;
	logic                   wait_done;
	logic                   wb_req;
	logic                   wb_wr_lane0;
	logic                   nmi_wake;
	logic                   wdt2_wake;
	logic                   mask_wake;
	logic                   halt_wake;
	logic                   idle_wake;
	logic                   any_reset;
	logic                   ack_next;

	// Address decode used by both read and write paths
	function automatic logic hit(input logic [31:0] adr, input logic [31:0] base);
		hit = (adr == base);
	endfunction : hit

	assign wb_req      = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wb_wr_lane0 = wb_req && wb_we_i && wb_sel_i[0];
	assign any_reset   = pin_reset_i || watchdog1_reset_i || watchdog2_reset_i;

	// Wake qualifiers with disable bits applied
	assign nmi_wake  = pin_nmi_i && !pwr_ctrl_reg[smc_pkg::BIT_NMI_DIS];
	assign wdt2_wake = watchdog2_interrupt_i && !pwr_ctrl_reg[smc_pkg::BIT_WDT2_DIS];
	assign mask_wake = !pwr_ctrl_reg[smc_pkg::BIT_MASK_DIS];
	// Halt wakes on pending requests too, so a pending one exits at once
	assign halt_wake = nmi_wake || wdt2_wake || watchdog1_interrupt_i
		|| (mask_wake && mask_req_i);
	// Idle: only sources alive without the main peripheral clock
	assign idle_wake = nmi_wake || (wdt2_wake && on_subclock_i)
		|| (mask_wake && (ext_pin_req_i || idle_live_req_i));

	// Acknowledge only if outranking the routine in service
	always_comb
	begin
		ack_next = 1'b0;
		if (nmi_wake || wdt2_wake || watchdog1_interrupt_i)
			ack_next = 1'b1;
		else if (mask_req_i && int_enabled_i)
			ack_next = !in_service_i || (mask_req_level_i < service_level_i);
	end

	// Bus answer one cycle after the strobe; unmapped addresses get err
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			if (wb_req)
			begin
				wb_dat_o <= 32'h0000_0000;
				if (hit(wb_adr_i, smc_pkg::ADDR_WAIT_SEL))
				begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {24'h000000, wait_sel_reg};
				end
				else if (hit(wb_adr_i, smc_pkg::ADDR_PWR_CTRL))
				begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {24'h000000, pwr_ctrl_reg};
				end
				else if (hit(wb_adr_i, smc_pkg::ADDR_PWR_MODE))
				begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {24'h000000, pwr_mode_reg};
				end
				else if (hit(wb_adr_i, smc_pkg::ADDR_PROTECT))
					wb_ack_o <= 1'b1;
				else if (hit(wb_adr_i, smc_pkg::ADDR_STATUS))
				begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {28'h0000000, unlock_reg, state_reg};
				end
				else
					wb_err_o <= 1'b1;
			end
		end
	end

	// Protect key arms exactly one following bus write
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			unlock_reg <= 1'b0;
		else if (wb_req && wb_we_i)
			unlock_reg <= hit(wb_adr_i, smc_pkg::ADDR_PROTECT) && wb_sel_i[0]
				&& wb_dat_i[7:0] == smc_pkg::PROTECT_KEY;
	end

	// Power save control; standby request cleared by hardware on wake
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pwr_ctrl_reg <= smc_pkg::RST_PWR_CTRL;
		else if (state_reg == smc_pkg::ST_SETTLE
			|| (state_reg == smc_pkg::ST_IDLE && idle_wake))
			pwr_ctrl_reg[smc_pkg::BIT_STANDBY] <= 1'b0;
		else if (wb_wr_lane0 && unlock_reg && hit(wb_adr_i, smc_pkg::ADDR_PWR_CTRL))
			pwr_ctrl_reg <= wb_dat_i[7:0] & smc_pkg::PWR_CTRL_MASK;
	end

	// Power save mode select, written by a lane-0 byte write
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pwr_mode_reg <= smc_pkg::RST_PWR_MODE;
		else if (wb_wr_lane0 && hit(wb_adr_i, smc_pkg::ADDR_PWR_MODE))
			pwr_mode_reg <= wb_dat_i[7:0] & smc_pkg::PWR_MODE_MASK;
	end

	// Wait select; only a full lane-0 byte write counts, upper bits read zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wait_sel_reg <= smc_pkg::RST_WAIT_SEL;
		else if (any_reset)
			wait_sel_reg <= smc_pkg::RST_WAIT_SEL; // Reset exit uses the reset wait
		else if (wb_wr_lane0 && hit(wb_adr_i, smc_pkg::ADDR_WAIT_SEL))
			wait_sel_reg <= wb_dat_i[7:0] & smc_pkg::WAIT_SEL_MASK;
	end

	// Mode sequencer; resets restart through the wait like a stop exit
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_reg <= smc_pkg::ST_RUN;
		else if (any_reset)
			state_reg <= smc_pkg::ST_OSC;
		else
		begin
			unique case (state_reg)
				smc_pkg::ST_RUN:
				begin
					if (pwr_ctrl_reg[smc_pkg::BIT_STANDBY])
						state_reg <= pwr_mode_reg[smc_pkg::BIT_DEEP]
							? smc_pkg::ST_STOP : smc_pkg::ST_IDLE;
					else if (halt_exec_i)
						state_reg <= smc_pkg::ST_HALT;
				end
				smc_pkg::ST_HALT:
					if (halt_wake)
						state_reg <= smc_pkg::ST_RUN;
				smc_pkg::ST_IDLE:
					if (idle_wake)
						state_reg <= smc_pkg::ST_RUN;
				smc_pkg::ST_STOP:
					if (idle_wake)
						state_reg <= smc_pkg::ST_OSC;
				smc_pkg::ST_OSC:
					if (osc_started_i)
						state_reg <= smc_pkg::ST_SETTLE;
				smc_pkg::ST_SETTLE:
					if (wait_done)
						state_reg <= smc_pkg::ST_RUN;
				default:
					state_reg <= smc_pkg::ST_RUN;
			endcase
		end
	end

	assign wait_start = state_reg == smc_pkg::ST_OSC && osc_started_i && !any_reset;

	// Stabilization counter, started once the oscillator runs
	smc_wait_counter #(
		.WIDTH   (smc_pkg::WAIT_EXP_MAX + 1)
	) u_wait (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (wait_start),
		.sel_i   (wait_sel_reg[2:0]),
		.done_o  (wait_done)
	);

	// Clock gates and wake indication, all registered
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cpu_clk_en_o    <= 1'b1;
			periph_clk_en_o <= 1'b1;
			osc_en_o        <= 1'b1;
			sys_reset_o     <= 1'b1;
			wake_o          <= 1'b0;
			wake_vector_o   <= 1'b0;
			ack_req_o       <= 1'b0;
		end
		else
		begin
			// Halt keeps peripherals and oscillator, idle keeps oscillator
			cpu_clk_en_o    <= state_reg == smc_pkg::ST_RUN;
			periph_clk_en_o <= state_reg == smc_pkg::ST_RUN
				|| state_reg == smc_pkg::ST_HALT;
			osc_en_o        <= state_reg != smc_pkg::ST_STOP;
			sys_reset_o     <= any_reset;
			wake_o          <= 1'b0;
			wake_vector_o   <= 1'b0;
			ack_req_o       <= 1'b0;
			if ((state_reg == smc_pkg::ST_HALT && halt_wake && !any_reset)
				|| ((state_reg == smc_pkg::ST_IDLE || state_reg == smc_pkg::ST_STOP)
				&& idle_wake && !any_reset))
			begin
				wake_o        <= 1'b1;
				ack_req_o     <= ack_next;
				wake_vector_o <= ack_next;
			end
		end
	end
endmodule : smc_standby_ctrl

// File: verification/smc_checker.sv
// Port assertions for the standby controller
`timescale 1ns/1ps
module smc_checker (
	// Clock, reset, bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	// Gates and release
	input wire logic cpu_clk_en_o,
	input wire logic periph_clk_en_o,
	input wire logic osc_en_o,
	input wire logic wake_o,
	input wire logic wake_vector_o,
	input wire logic ack_req_o,
	// Sources
	input wire logic watchdog1_interrupt_i,
	input wire logic pin_reset_i,
	input wire logic osc_started_i,
	input wire logic sys_reset_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Peripherals never stop while the CPU clock runs
	property p_gate; !periph_clk_en_o |-> !cpu_clk_en_o; endproperty
	a_gate: assert property (p_gate) else $error("periph off, cpu on");
	property p_osc; !osc_en_o |-> !periph_clk_en_o; endproperty
	a_osc: assert property (p_osc) else $error("osc off, periph on");
	property p_ack; ack_req_o |-> wake_o; endproperty
	a_ack: assert property (p_ack) else $error("ack without release");
	property p_vec; ack_req_o |-> wake_vector_o; endproperty
	a_vec: assert property (p_vec) else $error("ack without vector");
	// First watchdog always ends halt within a short bound
	property p_wdt;
		!cpu_clk_en_o && periph_clk_en_o && watchdog1_interrupt_i |-> ##[1:3] cpu_clk_en_o;
	endproperty
	a_wdt: assert property (p_wdt) else $error("halt kept");
	property p_sys; pin_reset_i |=> sys_reset_o; endproperty
	a_sys: assert property (p_sys) else $error("reset lost");
	// Settling is counted, never skipped, once the oscillator starts
	property p_wait; $rose(osc_started_i) && !cpu_clk_en_o |=> !cpu_clk_en_o [*8]; endproperty
	a_wait: assert property (p_wait) else $error("wait skipped");
	property p_ans; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o; endproperty
	a_ans: assert property (p_ans) else $error("bus unanswered");
endmodule : smc_checker

bind smc_standby_ctrl smc_checker smc_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o), .osc_en_o(osc_en_o),
	.wake_o(wake_o), .wake_vector_o(wake_vector_o), .ack_req_o(ack_req_o),
	.watchdog1_interrupt_i(watchdog1_interrupt_i), .pin_reset_i(pin_reset_i),
	.osc_started_i(osc_started_i), .sys_reset_o(sys_reset_o));

// File: verification/smc_core_model.sv
// Oscillator start-up and pending request model
`timescale 1ns/1ps
module smc_core_model #(
	parameter int START_CYC = 20
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// From controller and bench
	input  wire logic osc_en_i,
	input  wire logic ack_i,
	input  wire logic req_set_i,
	input  wire logic req_clr_i,
	// To controller
	output logic      osc_started_o,
	output logic      mask_req_o
);
	int cnt;
	// Start-up run not reported, so it never counts as settling
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !osc_en_i)
			cnt <= 0;
		else if (cnt < START_CYC)
			cnt <= cnt + 1;
	end
	assign osc_started_o = (cnt == START_CYC);
	// Request waits until acknowledged
	always_ff @(posedge clk_i)
	begin
		if (rst_i || req_clr_i || ack_i)
			mask_req_o <= 1'b0;
		else if (req_set_i)
			mask_req_o <= 1'b1;
	end
endmodule : smc_core_model

// File: verification/smc_standby_ctrl_tb.sv
// Self-checking bench for the standby controller
`timescale 1ns/1ps
module smc_standby_ctrl_tb;
	localparam logic [31:0] WS = smc_pkg::ADDR_WAIT_SEL;
	localparam logic [31:0] CTL = smc_pkg::ADDR_PWR_CTRL;
	localparam logic [31:0] MOD = smc_pkg::ADDR_PWR_MODE;
	logic        clk_i, rst_i, cyc, stb, we, hlt, svc, ien, nmi, wd1, ext, prst, rset, lerr;
	logic        ack, err, cpu, per, osc, wk, vec, akr, ost, mrq, srst, wd2;
	logic [3:0]  sel, slv, mlv;
	logic [7:0]  r, q[$];
	logic [31:0] adr, dat, rdat;
	int          num_errors, num_checks, wakes, acks, n, w0, a0;
	smc_standby_ctrl smc_standby_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .halt_exec_i(hlt), .in_service_i(svc),
		.service_level_i(slv), .int_enabled_i(ien), .cpu_clk_en_o(cpu), .periph_clk_en_o(per),
		.osc_en_o(osc), .wake_o(wk), .wake_vector_o(vec), .pin_nmi_i(nmi),
		.watchdog1_interrupt_i(wd1), .watchdog2_interrupt_i(wd2), .on_subclock_i(1'b0),
		.mask_req_i(mrq), .mask_req_level_i(mlv), .ext_pin_req_i(ext), .idle_live_req_i(1'b0),
		.ack_req_o(akr), .pin_reset_i(prst), .watchdog1_reset_i(1'b0),
		.watchdog2_reset_i(1'b0), .osc_started_i(ost), .sys_reset_o(srst));
	smc_core_model smc_core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .osc_en_i(osc),
		.ack_i(akr), .req_set_i(rset), .req_clr_i(1'b0), .osc_started_o(ost), .mask_req_o(mrq));
	// 200 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic ck(input bit ok, input string m);
		num_checks++;
		if (!ok)
		begin
			num_errors++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : ck
	task automatic finish_test();
		$display("Checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	task automatic tmo(input string m);
		ck(1'b0, m);
		finish_test();
	endtask : tmo
	// Classic single cycle; read expectation queued first
	task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d);
		@(posedge clk_i);
		if (!w)
			q.push_back(d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && err !== 1'b1 && n < 20);
		lerr = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20)
			tmo("bus");
	endtask : wb
	task automatic put_ctrl(input logic [7:0] d);
		wb(1'b1, smc_pkg::ADDR_PROTECT, smc_pkg::PROTECT_KEY);
		wb(1'b1, CTL, d);
	endtask : put_ctrl
	task automatic halt();
		@(posedge clk_i);
		hlt <= 1'b1;
		@(posedge clk_i);
		hlt <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : halt
	task automatic wcpu(input logic v, input int lim);
		n = 0;
		while (cpu !== v && n < lim)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= lim)
			tmo("gate wait");
	endtask : wcpu
	// Only cycles with the oscillator started count as settling
	task automatic meas(input int e, input string m);
		int k;
		wcpu(1'b0, 50);
		k = 0;
		n = 0;
		while (cpu !== 1'b1 && n < 40000)
		begin
			@(posedge clk_i);
			n++;
			k += (ost === 1'b1);
		end
		if (n >= 40000)
			tmo(m);
		ck(k >= (1 << e) && k <= (1 << e) + 4, m);
	endtask : meas
	// Read data against the oldest note
	always @(posedge clk_i)
	begin
		if (ack === 1'b1 && we === 1'b0)
			ck(q.size() > 0 && rdat === {24'h0, q.pop_front()}, "read data");
		wakes += (wk === 1'b1);
		acks += (akr === 1'b1);
	end
	initial
	begin
		{cyc, stb, we, hlt, svc, ien, nmi, wd1, wd2, ext, prst, rset} = '0;
		{sel, slv, mlv, adr, dat, rst_i} = {4'h1, 8'h00, 64'h0, 1'b1};
		{num_errors, num_checks, wakes, acks} = '0;
		r = 8'($urandom(32'hDDAC));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, WS, 8'h01);
		wb(1'b0, CTL, 8'h00);
		wb(1'b0, MOD, 8'h00);
		wb(1'b1, smc_pkg::ADDR_STATUS + 32'h10, 8'h00);
		ck(lerr === 1'b1, "unmapped");
		$display("Test reset done");
		// Key must come right before the control write
		wb(1'b1, CTL, 8'h30);
		wb(1'b0, CTL, 8'h00);
		put_ctrl(8'hB0);
		r = 8'($urandom());
		wb(1'b1, smc_pkg::ADDR_PROTECT, smc_pkg::PROTECT_KEY);
		wb(1'b1, MOD, r);
		wb(1'b1, CTL, 8'h02);
		wb(1'b0, CTL, 8'hB0);
		wb(1'b0, MOD, r & 8'h01);
		wb(1'b1, WS, 8'h05);
		sel <= 4'h0;
		wb(1'b1, WS, 8'h07);
		sel <= 4'h1;
		wb(1'b0, WS, 8'h05);
		$display("Test registers done");
		// All disables set: only the first watchdog releases halt
		wb(1'b1, MOD, 8'h00);
		halt();
		ck(cpu === 1'b0 && per === 1'b1 && osc === 1'b1, "halt gates");
		rset <= 1'b1;
		nmi <= 1'b1;
		wd2 <= 1'b1;
		@(posedge clk_i);
		rset <= 1'b0;
		repeat (20) @(posedge clk_i);
		ck(cpu === 1'b0, "disabled release");
		wd1 <= 1'b1;
		wcpu(1'b1, 10);
		{wd1, wd2, nmi} <= 3'b000;
		$display("Test halt done");
		// Lower priority request in service: release only, kept pending
		put_ctrl(8'h00);
		r = 8'($urandom_range(13, 1));
		slv <= r[3:0];
		mlv <= r[3:0] + 4'h1;
		{svc, ien, rset} <= 3'b111;
		@(posedge clk_i);
		rset <= 1'b0;
		{w0, a0} = {wakes, acks};
		halt();
		halt();
		ck(wakes == w0 + 2 && acks == a0 && mrq === 1'b1, "pending");
		svc <= 1'b0;
		halt();
		ck(acks == a0 + 1 && mrq === 1'b0, "ack");
		$display("Test priority done");
		// Idle: peripherals stop, pin request returns at once
		put_ctrl(8'h02);
		repeat (3) @(posedge clk_i);
		ck(cpu === 1'b0 && per === 1'b0 && osc === 1'b1, "idle gates");
		ext <= 1'b1;
		wcpu(1'b1, 6);
		ext <= 1'b0;
		wb(1'b0, CTL, 8'h00);
		$display("Test idle done");
		wb(1'b1, WS, 8'h00);
		wb(1'b1, MOD, 8'h01);
		ck(osc === 1'b1 && cpu === 1'b1, "mode alone");
		put_ctrl(8'h02);
		repeat (3) @(posedge clk_i);
		ck(osc === 1'b0 && cpu === 1'b0, "stop gates");
		nmi <= 1'b1;
		meas(13, "short wait");
		nmi <= 1'b0;
		prst <= 1'b1;
		@(posedge clk_i);
		prst <= 1'b0;
		meas(15, "reset wait");
		$display("Test stop done");
		finish_test();
	end
endmodule : smc_standby_ctrl_tb
